// *** design/dcb_pkg.sv ***
package dcb_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int APB_AW = 8;
  localparam int APB_DW = 32;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_HI0 = 8'h00;
  localparam logic [7:0] ADDR_LO0 = 8'h04;
  localparam logic [7:0] ADDR_HI1 = 8'h08;
  localparam logic [7:0] ADDR_LO1 = 8'h0c;
  localparam logic [7:0] ADDR_CTRL = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;
  localparam logic [7:0] ADDR_IDENT = 8'h18;

  // ----------------------------------------------------------------
  // field layouts and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_W = 14;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 14'h0000;
  localparam int STAT_W = 8;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ALL_ONES = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam int ID_DIGIT_W = 2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 1200;
  localparam int DESKEW_NS = 200;
  localparam logic [7:0] SETTLE_CYC = 8'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] DESKEW_CYC = 8'((DESKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int BASE_TICK_NS = 5000;
  localparam logic [8:0] BASE_TICK_CYC = 9'(BASE_TICK_NS / CLK_PERIOD_NS);
  localparam int TEST_HALF_NS = 100000;
  localparam logic [4:0] TEST_HALF_TICKS = 5'(TEST_HALF_NS / BASE_TICK_NS);
  localparam logic [3:0] DECADE = 4'ha;
  localparam int DECADES = 6;

  // ----------------------------------------------------------------
  // modes and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DCB_MODE_X = 2'h0,
    DCB_MODE_AND = 2'h1,
    DCB_MODE_OR = 2'h2,
    DCB_MODE_PERIOD = 2'h3
  } dcb_mode_e;

  typedef struct packed {
    logic [1:0] tsel1;
    logic [1:0] tsel0;
    logic [1:0] fsel1;
    logic [1:0] fsel0;
    dcb_mode_e mode1;
    dcb_mode_e mode0;
    logic field_disable_bit;
    logic test_select_bit;
  } dcb_cfg_s;

  typedef struct packed {
    logic load;
    logic arm;
    logic [15:0] load_value;
    logic hold;
    logic counted_signal;
    logic window;
  } dcb_ctr_in_s;

  typedef struct packed {
    logic [15:0] count;
    logic overflow;
    logic enabled;
    logic armed;
    logic ext_flag;
  } dcb_ctr_out_s;

  typedef struct packed {
    logic [3:0] freq;
    logic [3:0] tbase;
  } dcb_base_s;

endpackage

// *** design/dcb_timebase.sv ***
`timescale 1ns/10ps
module dcb_timebase
  import dcb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic test_select_bit,
  output dcb_base_s bases
);

  // ----------------------------------------------------------------
  // 5 us prescaler and decade chain
  // ----------------------------------------------------------------
  logic [8:0] pre_cnt;
  logic base_tick;
  logic [DECADES:0] tick;
  logic [DECADES:0] sq;
  logic [3:0] dec_cnt [DECADES];
  logic [4:0] test_cnt;
  logic sq_test;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pre_cnt <= 9'h000;
      base_tick <= 1'b0;
    end else if (pre_cnt == BASE_TICK_CYC - 9'h001) begin
      pre_cnt <= 9'h000;
      base_tick <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 9'h001;
      base_tick <= 1'b0;
    end
  end

  assign tick[0] = base_tick;

  for (genvar i = 0; i < DECADES; i++) begin : g_dec
    assign tick[i+1] = tick[i] & (dec_cnt[i] == DECADE - 4'h1);
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        dec_cnt[i] <= 4'h0;
      end else if (tick[i]) begin
        dec_cnt[i] <= (dec_cnt[i] == DECADE - 4'h1) ? 4'h0 : dec_cnt[i] + 4'h1;
      end
    end
  end

  // squares: 100k, 10k, 1k, 100 Hz, then 100 ms, 1 s, 10 s periods
  for (genvar i = 0; i <= DECADES; i++) begin : g_sq
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        sq[i] <= 1'b0;
      end else if (tick[i]) begin
        sq[i] <= ~sq[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      test_cnt <= 5'h00;
      sq_test <= 1'b0;
    end else if (tick[0]) begin
      if (test_cnt == TEST_HALF_TICKS - 5'h01) begin
        test_cnt <= 5'h00;
        sq_test <= ~sq_test;
      end else begin
        test_cnt <= test_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bases <= '0;
    end else begin
      bases.freq <= test_select_bit ? {4{sq_test}} : sq[3:0]; // [R22]
      bases.tbase <= test_select_bit ? {4{sq[6]}} : sq[6:3]; // [R22]
    end
  end

endmodule

// *** design/dcb_counter_unit.sv ***
`timescale 1ns/10ps
module dcb_counter_unit
  import dcb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire dcb_ctr_in_s ctl,
  output dcb_ctr_out_s stat
);

  logic sig_prev;
  logic win_prev;
  logic pending;
  logic armed;
  logic enabled;
  logic [15:0] count;
  logic sig_rise;

  assign sig_rise = ctl.counted_signal & ~sig_prev & enabled;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sig_prev <= 1'b0;
      win_prev <= 1'b0;
    end else begin
      sig_prev <= ctl.counted_signal;
      win_prev <= ctl.window;
    end
  end

  // ----------------------------------------------------------------
  // arming and counting window
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      armed <= 1'b0;
      enabled <= 1'b0;
    end else if (ctl.load) begin
      armed <= ctl.arm; // [R21]
      enabled <= 1'b0;
    end else if (armed && ctl.window && !win_prev) begin
      armed <= 1'b0; // [R21]
      enabled <= 1'b1;
    end else if (enabled && !ctl.window && win_prev) begin
      enabled <= 1'b0; // [R21]
    end
  end

  // ----------------------------------------------------------------
  // count with anticoincidence hold
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= CNT_ZERO; // [R5]
      pending <= 1'b0;
    end else if (ctl.load) begin
      count <= ctl.load_value; // [R1]
      pending <= 1'b0;
    end else if (ctl.hold) begin
      if (sig_rise) begin
        pending <= 1'b1; // [R10] [R11]
      end
    end else begin
      count <= count + {15'h0000, sig_rise} + {15'h0000, pending}; // [R2] [R24]
      pending <= 1'b0; // [R24]
    end
  end

  always_comb begin
    stat.count = count;
    stat.overflow = (count == CNT_ALL_ONES); // [R15]
    stat.enabled = enabled;
    stat.armed = armed;
    stat.ext_flag = 1'b0; // [R3]
  end

endmodule

// *** design/dcb_dual_counter.sv ***
// Contract
// (R1) two independent 16-bit presettable up counters
// (R2) counter preset to zero counts 65,535 events to all ones
// (R3) extra flag stage beside each counter MSB is held cleared
// (R4) each counter reads its own identity code, low digit chosen per counter
// (R5) initialize or test-bit entry zeroes data path and loads both counters; test-bit entry here clears in_buf but not out_buf or prdata
// (R6) high-byte write buffered; low-byte write loads both bytes together
// (R7) controller writes high byte before low byte
// (R8) high-byte read drives high byte and captures low byte into buffer
// (R9) one input buffer and one output buffer shared by both counters
// (R10) counting inhibited while a high byte is read
// (R11) count edge during high read held, applied after strobe negates
// (R12) high-byte read delays capture and reply by 1.2 us
// (R13) low-byte read neither holds counting nor waits the settle delay
// (R14) every read reply delayed at least 0.2 us after selection
// (R15) overflow asserted at all ones, the only status the control uses
// (R16) four byte addresses: high and low byte of each counter; the code also decodes control, status and identity at 8'h10, 8'h14, 8'h18
// (R17) one shared generator supplies frequencies and time bases
// (R18) per-counter mode select forms counted signal and counting window
// (R19) test operation, field disable and identity readback are supported
// (R20) controller reads high byte before low byte
// (R21) low-byte write arms; count from next window rise to its fall
// (R22) test bit makes generator give 5 kHz and a ten-second time base
// (R23) delays are whole clock counts; async inputs pass two flip-flops
// (R24) a held count edge is counted exactly once after release
`timescale 1ns/10ps
module dcb_dual_counter
  import dcb_pkg::*;
#(
  parameter logic [7:0] ID_BASE = 8'h5c // value arbitrary
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  output logic [APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] field_x,
  input wire logic [1:0] field_y,
  input wire logic [ID_DIGIT_W-1:0] id_digit0,
  input wire logic [ID_DIGIT_W-1:0] id_digit1,
  output logic [1:0] counter_enable_out,
  output logic [1:0] counter_overflow
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  dcb_cfg_s cfg;
  dcb_base_s bases;
  dcb_ctr_in_s ctr_in [2];
  dcb_ctr_out_s ctr_out [2];

  // pin sync
  logic [1:0] fx_meta;
  logic [1:0] fx_sync;
  logic [1:0] fy_meta;
  logic [1:0] fy_sync;
  logic [2*ID_DIGIT_W-1:0] id_meta;
  logic [2*ID_DIGIT_W-1:0] id_sync;

  // buffers, timer
  logic [7:0] in_buf;
  logic [7:0] out_buf;
  logic [7:0] wait_cnt;
  logic test_prev;
  logic init_pulse;

  // bus decode
  logic setup_ph;
  logic access_ph;
  logic wr_done;
  logic strobe;
  logic [1:0] sel_hi;
  logic [1:0] sel_lo;
  logic sel_ctrl;
  logic sel_stat;
  logic sel_ident;
  logic unmapped;

  // mode select
  logic [1:0] fx;
  logic [1:0] fy;

  // read path
  logic [7:0] ident [2];
  logic [APB_DW-1:0] next_rdata;
  logic [7:0] next_wait;

  // ----------------------------------------------------------------
  // synchronisers for field and strap pins
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      fx_meta <= 2'h0;
      fx_sync <= 2'h0;
      fy_meta <= 2'h0;
      fy_sync <= 2'h0;
    end else begin
      fx_meta <= field_x;
      fx_sync <= fx_meta; // [R23]
      fy_meta <= field_y;
      fy_sync <= fy_meta; // [R23]
    end
  end

  // id straps
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      id_meta <= 4'h0;
      id_sync <= 4'h0;
    end else begin
      id_meta <= {id_digit1, id_digit0};
      id_sync <= id_meta; // [R23]
    end
  end

  // identity code: fixed upper bits, low digit strapped per counter
  assign ident[0] = {ID_BASE[7:2], id_sync[1:0]}; // [R4]
  assign ident[1] = {ID_BASE[7:2], id_sync[3:2]}; // [R4]

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // apb phases
  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;

  // selects
  always_comb begin
    sel_hi[0] = (paddr == ADDR_HI0); // [R16]
    sel_lo[0] = (paddr == ADDR_LO0);
    sel_hi[1] = (paddr == ADDR_HI1);
    sel_lo[1] = (paddr == ADDR_LO1);
    sel_ctrl = (paddr == ADDR_CTRL);
    sel_stat = (paddr == ADDR_STAT);
    sel_ident = (paddr == ADDR_IDENT);

    unmapped = ~(|sel_hi | |sel_lo | sel_ctrl | sel_stat | sel_ident);
  end

  // ----------------------------------------------------------------
  // reply timing
  // ----------------------------------------------------------------
  // wait length
  always_comb begin
    if (pwrite) begin
      next_wait = 8'h00;
    end else if (|sel_hi) begin
      next_wait = SETTLE_CYC; // [R12]
    end else begin
      next_wait = DESKEW_CYC; // [R13] [R14]
    end
  end

  // wait counter
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_cnt <= 8'h00;
    end else if (setup_ph) begin
      wait_cnt <= next_wait; // [R23]
    end else if (access_ph && wait_cnt != 8'h00) begin
      wait_cnt <= wait_cnt - 8'h01;
    end
  end

  // apb reply
  assign pready = access_ph & (wait_cnt == 8'h00);
  assign pslverr = pready & unmapped;
  assign wr_done = pready & pwrite;
  // delayed capture strobe, one cycle ahead of the reply
  assign strobe = access_ph & ~pwrite & (wait_cnt == 8'h01);

  // ----------------------------------------------------------------
  // read data and shared output buffer
  // ----------------------------------------------------------------
  // read mux
  always_comb begin
    next_rdata = '0;
    if (sel_hi[0]) begin
      next_rdata[7:0] = ctr_out[0].count[15:8]; // [R8]
    end else if (sel_hi[1]) begin
      next_rdata[7:0] = ctr_out[1].count[15:8]; // [R8]
    end else if (|sel_lo) begin
      next_rdata[7:0] = out_buf; // [R8] [R13]
    end else if (sel_ctrl) begin
      next_rdata[CTRL_W-1:0] = cfg;
    end else if (sel_stat) begin
      next_rdata[STAT_W-1:0] = {ctr_out[1].ext_flag, ctr_out[0].ext_flag,
                                ctr_out[1].armed, ctr_out[0].armed,
                                ctr_out[1].enabled, ctr_out[0].enabled,
                                ctr_out[1].overflow, ctr_out[0].overflow};
    end else if (sel_ident) begin
      next_rdata[15:0] = {ident[1], ident[0]}; // [R4] [R19]
    end
  end

  // read data
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= '0;
    end else if (strobe) begin
      prdata <= next_rdata;
    end
  end

  // low snapshot
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_buf <= 8'h00;
    end else if (strobe && sel_hi[0]) begin
      out_buf <= ctr_out[0].count[7:0]; // [R8] [R9] [R12]
    end else if (strobe && sel_hi[1]) begin
      out_buf <= ctr_out[1].count[7:0]; // [R8] [R9] [R12]
    end
  end

  // ----------------------------------------------------------------
  // writes: shared input buffer and control register
  // ----------------------------------------------------------------
  // high staging
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_buf <= 8'h00;
    end else if (init_pulse) begin
      in_buf <= 8'h00; // [R5]
    end else if (wr_done && |sel_hi) begin
      in_buf <= pwdata[7:0]; // [R6] [R9]
    end
  end

  // control
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= CTRL_RESET;
    end else if (wr_done && sel_ctrl) begin
      cfg <= pwdata[CTRL_W-1:0]; // [R19]
    end
  end

  // ----------------------------------------------------------------
  // initialise on test-bit entry
  // ----------------------------------------------------------------
  // test edge
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      test_prev <= 1'b0;
    end else begin
      test_prev <= cfg.test_select_bit;
    end
  end

  // init pulse
  assign init_pulse = cfg.test_select_bit & ~test_prev; // [R5]

  // ----------------------------------------------------------------
  // shared frequency and time base generator
  // ----------------------------------------------------------------
  dcb_timebase u_timebase (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .test_select_bit(cfg.test_select_bit),
    .bases(bases) // [R17]
  );

  // ----------------------------------------------------------------
  // mode select and counter control
  // ----------------------------------------------------------------
  // disabled field inputs read as zero
  assign fx = fx_sync & {2{~cfg.field_disable_bit}}; // [R19]
  assign fy = fy_sync & {2{~cfg.field_disable_bit}}; // [R19]

  always_comb begin
    dcb_mode_e mode;
    logic freq;
    logic tb;
    mode = DCB_MODE_X;
    freq = 1'b0;
    tb = 1'b0;

    for (int c = 0; c < 2; c++) begin
      mode = (c == 0) ? cfg.mode0 : cfg.mode1;
      freq = bases.freq[(c == 0) ? cfg.fsel0 : cfg.fsel1];
      tb = bases.tbase[(c == 0) ? cfg.tsel0 : cfg.tsel1];
      ctr_in[c].window = tb;

      case (mode) // [R18]
        DCB_MODE_X: begin
          ctr_in[c].counted_signal = fx[c];
        end
        DCB_MODE_AND: begin
          ctr_in[c].counted_signal = fx[c] & fy[c];
        end
        DCB_MODE_OR: begin
          ctr_in[c].counted_signal = fx[c] | fy[c];
        end
        DCB_MODE_PERIOD: begin
          ctr_in[c].counted_signal = freq;
          ctr_in[c].window = fx[c];
        end
        default: begin
          ctr_in[c].counted_signal = 1'b0;
        end
      endcase

      // hold spans the whole high-byte read until psel falls
      ctr_in[c].hold = psel & ~pwrite & sel_hi[c]; // [R10] [R11] [R13]
      ctr_in[c].arm = wr_done & sel_lo[c]; // [R21]
      ctr_in[c].load = init_pulse | (wr_done & sel_lo[c]); // [R5] [R6]
      ctr_in[c].load_value = init_pulse ? CNT_ZERO : {in_buf, pwdata[7:0]}; // [R5] [R6]
    end
  end

  // counters
  for (genvar c = 0; c < 2; c++) begin : g_ctr
    dcb_counter_unit u_ctr (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .ctl(ctr_in[c]),
      .stat(ctr_out[c]) // [R1]
    );
  end

  // ----------------------------------------------------------------
  // field-side outputs
  // ----------------------------------------------------------------
  // field pins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      counter_enable_out <= 2'h0;
      counter_overflow <= 2'h0;
    end else begin
      counter_enable_out <= {ctr_out[1].enabled, ctr_out[0].enabled}
                            & {2{~cfg.field_disable_bit}}; // [R19]
      counter_overflow <= {ctr_out[1].overflow, ctr_out[0].overflow}; // [R15]
    end
  end

endmodule

// *** tb/dcb_dual_counter_checker.sv ***
`timescale 1ns/10ps
module dcb_dual_counter_checker
  import dcb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [APB_DW-1:0] pwdata,
  input wire logic [APB_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] counter_enable_out,
  input wire logic [1:0] counter_overflow
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic [7:0] acc_cnt;
  logic [1:0] ctl_q;
  logic hi_sel;
  logic mapped;
  assign hi_sel = (paddr == ADDR_HI0) || (paddr == ADDR_HI1);
  assign mapped = hi_sel || (paddr == ADDR_LO0) || (paddr == ADDR_LO1) ||
                  (paddr == ADDR_CTRL) || (paddr == ADDR_STAT) || (paddr == ADDR_IDENT);

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_cnt <= 8'h00;
    end else if (psel && penable && !pready) begin
      acc_cnt <= acc_cnt + 8'h01;
    end else begin
      acc_cnt <= 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctl_q <= 2'h0;
    end else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) begin
      ctl_q <= pwdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_done;
    psel && penable && pready;
  endsequence
  sequence s_rd_done;
    s_done ##0 !pwrite;
  endsequence
  sequence s_test_entry;
    s_done ##0 (pwrite && paddr == ADDR_CTRL && pwdata[0] && !ctl_q[0]);
  endsequence

  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("reply outside access phase");
  a_hi_read_settle: assert property (s_rd_done ##0 hi_sel |-> acc_cnt == SETTLE_CYC)
    else $error("high read reply not at settle count");
  a_lo_read_deskew: assert property (s_rd_done ##0 !hi_sel |-> acc_cnt == DESKEW_CYC)
    else $error("other read reply not at deskew count");
  a_write_no_wait: assert property (s_done ##0 pwrite |-> acc_cnt == 8'h00)
    else $error("write reply delayed");
  a_unmapped_err: assert property (s_done ##0 !mapped |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (s_done ##0 mapped |-> !pslverr)
    else $error("mapped access flagged as error");
  a_test_entry_clears: assert property (s_test_entry |-> ##[1:4] counter_overflow == 2'h0)
    else $error("overflow still set after test entry");
  a_disable_quiet: assert property (ctl_q[1] && $past(ctl_q[1], 3) |-> counter_enable_out == 2'h0)
    else $error("enable output active while disabled");
  a_rdata_hold: assert property (!(psel && !pwrite) |=> $stable(prdata))
    else $error("read data changed without a read");
endmodule

bind dcb_dual_counter dcb_dual_counter_checker u_chk (
  .ref_clk(ref_clk),
  .reset_n(reset_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .counter_enable_out(counter_enable_out),
  .counter_overflow(counter_overflow)
);

// *** tb/dcb_bus_master.sv ***
`timescale 1ns/10ps
module dcb_bus_master
  import dcb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [APB_DW-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [APB_AW-1:0] paddr,
  output logic [APB_DW-1:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // released lines show the inverse
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rdata_o, output logic err, output int nw);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    nw = 0;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      nw++;
      @(posedge ref_clk);
    end
    rdata_o = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= ~wr;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// *** tb/dcb_dual_counter_tb.sv ***
`timescale 1ns/10ps
module dcb_dual_counter_tb
  import dcb_pkg::*;
();
  localparam logic [7:0] ID_B = 8'ha4; // value arbitrary
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [APB_AW-1:0] paddr;
  logic [APB_DW-1:0] pwdata, prdata, rdv;
  logic [1:0] field_x = 2'h0;
  logic [1:0] field_y = 2'h0;
  logic [ID_DIGIT_W-1:0] id_digit0 = 2'h0;
  logic [ID_DIGIT_W-1:0] id_digit1 = 2'h0;
  logic [1:0] counter_enable_out, counter_overflow;
  logic err;
  logic [15:0] v0, v1;
  int miscompares = 0;
  int n_tests = 0;
  int seed = 33;
  int nw;

  always #5 ref_clk = ~ref_clk;

  dcb_dual_counter #(.ID_BASE(ID_B)) DUT (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .field_x(field_x), .field_y(field_y),
    .id_digit0(id_digit0), .id_digit1(id_digit1), .counter_enable_out(counter_enable_out),
    .counter_overflow(counter_overflow));
  dcb_bus_master bm (.ref_clk(ref_clk), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  // ----------------------------------------------------------------
  // expectations and bus tasks
  // ----------------------------------------------------------------
  function automatic logic unmapped(input logic [7:0] a);
    return !(a inside {ADDR_HI0, ADDR_LO0, ADDR_HI1, ADDR_LO1, ADDR_CTRL, ADDR_STAT, ADDR_IDENT});
  endfunction
  function automatic logic [31:0] exp_ident(input logic [1:0] d0, input logic [1:0] d1);
    return {16'h0, ID_B[7:2], d1, ID_B[7:2], d0};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bm.xfer(1'b1, a, d, rdv, err, nw);
    chk("write error flag", 32'(unmapped(a)), 32'(err));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bm.xfer(1'b0, a, 32'h0, d, err, nw);
    chk("read error flag", 32'(unmapped(a)), 32'(err));
    chk("read waits", (a == ADDR_HI0 || a == ADDR_HI1) ? 32'(SETTLE_CYC) : 32'(DESKEW_CYC), 32'(nw));
  endtask
  task automatic finish_test();
    $display("counts: %0d checks, %0d mismatches", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge ref_clk);
    miscompares++;
    $display("watchdog expired");
    finish_test();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    for (int k = 0; k < 4; k++) begin
      rd(8'(4 * k), rdv);
      chk("reset byte", 32'h0, rdv & 32'hff);
    end
    rd(ADDR_STAT, rdv);
    chk("status", 32'h0, rdv & 32'hff);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      v0 = 16'($random(seed));
      v1 = 16'($random(seed));
      field_y <= 2'($random(seed));
      wr(ADDR_HI0, 32'(v0[15:8]));
      wr(ADDR_LO0, 32'(v0[7:0]));
      wr(ADDR_HI1, 32'(v1[15:8]));
      wr(ADDR_LO1, 32'(v1[7:0]));
      rd(ADDR_HI1, rdv);
      chk("counter1 high", 32'(v1[15:8]), rdv & 32'hff);
      rd(ADDR_HI0, rdv);
      chk("counter0 high", 32'(v0[15:8]), rdv & 32'hff);
      rd(ADDR_LO1, rdv);
      chk("shared output buffer", 32'(v0[7:0]), rdv & 32'hff);
      rd(ADDR_LO0, rdv);
      chk("counter0 low", 32'(v0[7:0]), rdv & 32'hff);
    end
    wr(ADDR_HI0, 32'h5a);
    wr(ADDR_LO1, 32'hc3);
    rd(ADDR_HI1, rdv);
    chk("shared input buffer", 32'h5a, rdv & 32'hff);
    rd(ADDR_LO1, rdv);
    chk("low after shared", 32'hc3, rdv & 32'hff);
    $display("test load and read done");
    wr(ADDR_CTRL, 32'h1);
    repeat (4) @(posedge ref_clk);
    for (int k = 0; k < 4; k++) begin
      rd(8'(4 * k), rdv);
      chk("test entry clear", 32'h0, rdv & 32'hff);
    end
    wr(ADDR_CTRL, 32'h0);
    $display("test clear done");
    for (int i = 0; i < 4; i++) begin
      id_digit0 <= 2'(i);
      id_digit1 <= 2'(3 - i);
      repeat (4) @(posedge ref_clk);
      rd(ADDR_IDENT, rdv);
      chk("identity", exp_ident(2'(i), 2'(3 - i)), rdv & 32'hffff);
    end
    rd(8'h1c, rdv);
    wr(8'h20, 32'h0);
    $display("test identity and map done");
    wr(ADDR_CTRL, 32'h0c);
    wr(ADDR_HI0, 32'hff);
    wr(ADDR_LO0, 32'hfe);
    chk("overflow early", 32'h0, 32'(counter_overflow[0]));
    field_x <= 2'h1;
    for (int t = 0; t < 100 && counter_enable_out[0] !== 1'b1; t++) @(posedge ref_clk);
    chk("enable after window rise", 32'h1, 32'(counter_enable_out[0]));
    for (int t = 0; t < 3000 && counter_overflow[0] !== 1'b1; t++) @(posedge ref_clk);
    chk("overflow at all ones", 32'h1, 32'(counter_overflow[0]));
    rd(ADDR_HI0, rdv);
    chk("high at all ones", 32'hff, rdv & 32'hff);
    rd(ADDR_LO0, rdv);
    chk("low at all ones", 32'hff, rdv & 32'hff);
    wr(ADDR_CTRL, 32'h0e);
    repeat (4) @(posedge ref_clk);
    chk("enable while disabled", 32'h0, 32'(counter_enable_out));
    wr(ADDR_CTRL, 32'h0);
    field_x <= 2'h0;
    $display("test counting done");
    finish_test();
  end
endmodule
